//--- hdl/arb_bank.sv
// housekeeping converter disable bits and result word register bank
// Operation
// - bit7 stops positive data-line conversions
// - bit6 stops negative data-line conversions
// - bit5 stops source2 voltage conversions
// - bit4 stops source1 voltage conversions
// - input current word at 0x31, resets zero
// - input current signed, 1 mA per bit
// - battery current signed word at 0x33
// - charging current reads positive
// - discharge negative only when sensing enabled
// - bus voltage unsigned word at 0x35
// - source1 voltage unsigned word at 0x37
// - source2 voltage unsigned word at 0x39
// - battery voltage unsigned word at 0x3b
// - battery voltage from remote sense input
// - convert only while global enable set
// - rate bit: continuous or one shot
`timescale 1ns/10ps
`default_nettype none
module arb_bank (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_reg_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_conv_enable,
  input wire logic i_one_shot,
  input wire logic i_discharge_sense_enable,
  input wire logic i_sample_valid,
  input wire logic [2:0] i_sample_ch,
  input wire logic [15:0] i_sample_data,
  input wire logic i_sample_charging,
  output logic o_pos_dataline_conv_off,
  output logic o_neg_dataline_conv_off,
  output logic o_source2_conv_off,
  output logic o_source1_conv_off,
  output logic o_conv_active,
  output logic o_pass_done
);
  import arb_pkg::*;

  // disable bits
  logic [3:0] dis_reg;
  logic [3:0] dis_next;
  always_comb
  begin
    dis_next = dis_reg;
    if (i_reg_rst)
      dis_next = ARB_DISABLE_RST;
    else if (i_wr && i_addr == ARB_OFS_DISABLE)
      dis_next = i_wdata[ARB_BIT_POS_DL:ARB_BIT_SRC1];
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      dis_reg <= ARB_DISABLE_RST;
    else
      dis_reg <= dis_next;
  end
  assign o_pos_dataline_conv_off = dis_reg[ARB_BIT_POS_DL - ARB_BIT_SRC1];
  assign o_neg_dataline_conv_off = dis_reg[ARB_BIT_NEG_DL - ARB_BIT_SRC1];
  assign o_source2_conv_off = dis_reg[ARB_BIT_SRC2 - ARB_BIT_SRC1];
  assign o_source1_conv_off = dis_reg[0];

  // conversion sequencing
  arb_state_t st_reg;
  arb_state_t st_next;
  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      ARB_IDLE:
      begin
        if (i_conv_enable)
          st_next = ARB_RUN;
      end
      ARB_RUN:
      begin
        if (!i_conv_enable)
          st_next = ARB_IDLE;
        else if (i_sample_valid && i_sample_ch == 3'(ARB_CH_VBAT))
        begin
          if (i_one_shot)
            st_next = ARB_DONE;
        end
      end
      ARB_DONE:
      begin
        if (!i_conv_enable || !i_one_shot)
          st_next = ARB_IDLE;
      end
      default:
        st_next = ARB_IDLE;
    endcase
    if (i_reg_rst)
      st_next = ARB_IDLE;
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_reg <= ARB_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  assign o_conv_active = (st_reg == ARB_RUN) && i_conv_enable;
  assign o_pass_done = (st_reg == ARB_DONE);

  // accept samples, apply sign policy for battery current
  function automatic logic ch_blocked(input logic [2:0] ch, input logic [3:0] d);
    ch_blocked = (ch == 3'(ARB_CH_SRC1) && d[0]) || (ch == 3'(ARB_CH_SRC2) && d[1]);
  endfunction : ch_blocked
  logic wr_en;
  logic [15:0] wr_val;
  always_comb
  begin
    wr_en = o_conv_active && i_sample_valid && (int'(i_sample_ch) < ARB_NUM_CH)
            && !ch_blocked(i_sample_ch, dis_reg);
    wr_val = i_sample_data;
    if (i_sample_ch == 3'(ARB_CH_IBAT))
    begin
      if (i_sample_charging)
        wr_val = i_sample_data;
      else if (!i_discharge_sense_enable)
        wr_val = 16'h0000;
      else
        wr_val = 16'(-i_sample_data);
    end
  end

  // address map to word index and hit flag
  function automatic logic [3:0] map_addr(input logic [7:0] a);
    case (a)
      ARB_OFS_IBUS, ARB_OFS_IBUS + 8'h01: map_addr = {1'b1, 3'(ARB_CH_IBUS)};
      ARB_OFS_IBAT, ARB_OFS_IBAT + 8'h01: map_addr = {1'b1, 3'(ARB_CH_IBAT)};
      ARB_OFS_VBUS, ARB_OFS_VBUS + 8'h01: map_addr = {1'b1, 3'(ARB_CH_VBUS)};
      ARB_OFS_SRC1, ARB_OFS_SRC1 + 8'h01: map_addr = {1'b1, 3'(ARB_CH_SRC1)};
      ARB_OFS_SRC2, ARB_OFS_SRC2 + 8'h01: map_addr = {1'b1, 3'(ARB_CH_SRC2)};
      ARB_OFS_VBAT, ARB_OFS_VBAT + 8'h01: map_addr = {1'b1, 3'(ARB_CH_VBAT)};
      default: map_addr = 4'h0;
    endcase
  endfunction : map_addr
  logic [3:0] amap;
  logic [15:0] mem_rdata;
  assign amap = map_addr(i_addr);
  arb_result_mem #(.DEPTH(ARB_NUM_CH)) u_mem (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_clr(i_reg_rst),
    .i_we(wr_en),
    .i_waddr(i_sample_ch),
    .i_wdata(wr_val),
    .i_raddr(amap[2:0]),
    .o_rdata(mem_rdata)
  );

  // read pipeline, one cycle after the request
  logic rv_reg;
  logic rv_next;
  logic [1:0] sel_reg;
  logic [1:0] sel_next;
  logic [7:0] disrd_reg;
  logic [7:0] disrd_next;
  always_comb
  begin
    rv_next = i_rd;
    sel_next = 2'h0;
    disrd_next = {dis_reg, 4'h0};
    if (i_addr == ARB_OFS_DISABLE)
      sel_next = 2'h1;
    else if (amap[3])
      sel_next = (i_addr[0] == ARB_OFS_IBUS[0]) ? 2'h2 : 2'h3;
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rv_reg <= 1'b0;
      sel_reg <= 2'h0;
      disrd_reg <= 8'h00;
    end
    else
    begin
      rv_reg <= rv_next;
      sel_reg <= sel_next;
      disrd_reg <= disrd_next;
    end
  end
  always_comb
  begin
    case (sel_reg)
      2'h1: o_rdata = disrd_reg;
      2'h2: o_rdata = mem_rdata[15:8];
      2'h3: o_rdata = mem_rdata[7:0];
      default: o_rdata = 8'h00;
    endcase
  end
  assign o_rvalid = rv_reg;

  // checks
  sequence s_dis_write;
    i_wr && !i_reg_rst && i_addr == ARB_OFS_DISABLE;
  endsequence
  property p_dis_write;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    s_dis_write |=> o_pos_dataline_conv_off == $past(i_wdata[ARB_BIT_POS_DL]);
  endproperty
  a_dis_write: assert property (p_dis_write) else $error("pos line bit not stored");
  property p_neg;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    s_dis_write |=> o_neg_dataline_conv_off == $past(i_wdata[ARB_BIT_NEG_DL]);
  endproperty
  a_neg: assert property (p_neg) else $error("neg line bit not stored");
  property p_src2;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    s_dis_write |=> o_source2_conv_off == $past(i_wdata[ARB_BIT_SRC2]);
  endproperty
  a_src2: assert property (p_src2) else $error("source2 bit not stored");
  property p_src1_rst;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_reg_rst |=> !o_source1_conv_off && !o_source2_conv_off;
  endproperty
  a_src1_rst: assert property (p_src1_rst) else $error("disable bits survive reset");
  property p_no_conv_off;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    !i_conv_enable |-> !o_conv_active && !wr_en;
  endproperty
  a_no_conv_off: assert property (p_no_conv_off) else $error("conversion while disabled");
  sequence s_last_in_one_shot;
    o_conv_active && i_one_shot && !i_reg_rst && i_sample_valid && i_sample_ch == 3'(ARB_CH_VBAT);
  endsequence
  property p_one_shot;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    s_last_in_one_shot |=> o_pass_done;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one shot pass not ended");
  property p_dis_sign;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (wr_en && i_sample_ch == 3'(ARB_CH_IBAT) && !i_sample_charging && !i_discharge_sense_enable)
      |-> wr_val == 16'h0000;
  endproperty
  a_dis_sign: assert property (p_dis_sign) else $error("discharge reported unsensed");
  property p_chg_pos;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_sample_ch == 3'(ARB_CH_IBAT) && i_sample_charging) |-> wr_val == i_sample_data;
  endproperty
  a_chg_pos: assert property (p_chg_pos) else $error("charge current altered");
  property p_rvalid;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_rd |=> o_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  property p_src1_write;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    s_dis_write |=> o_source1_conv_off == $past(i_wdata[ARB_BIT_SRC1]);
  endproperty
  a_src1_write: assert property (p_src1_write) else $error("source1 bit not stored");
  property p_dl_rst;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_reg_rst |=> !o_pos_dataline_conv_off && !o_neg_dataline_conv_off;
  endproperty
  a_dl_rst: assert property (p_dl_rst) else $error("data-line bits survive reset");
  property p_wr_ignored;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_wr && !i_reg_rst && i_addr != ARB_OFS_DISABLE) |=> dis_reg == $past(dis_reg);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("disable bits changed");
  property p_dis_rd;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_rd && i_addr == ARB_OFS_DISABLE) |=> o_rdata == {$past(dis_reg), 4'h0};
  endproperty
  a_dis_rd: assert property (p_dis_rd) else $error("disable byte read wrong");
  property p_unmapped_rd;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_rd && i_addr != ARB_OFS_DISABLE && !amap[3]) |=> o_rdata == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  property p_rvalid_once;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    !i_rd |=> !o_rvalid;
  endproperty
  a_rvalid_once: assert property (p_rvalid_once) else $error("read answer repeated");
  property p_src1_blocked;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_sample_valid && i_sample_ch == 3'(ARB_CH_SRC1) && o_source1_conv_off) |-> !wr_en;
  endproperty
  a_src1_blocked: assert property (p_src1_blocked) else $error("source1 stored while off");
  property p_src2_blocked;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (i_sample_valid && i_sample_ch == 3'(ARB_CH_SRC2) && o_source2_conv_off) |-> !wr_en;
  endproperty
  a_src2_blocked: assert property (p_src2_blocked) else $error("source2 stored while off");
  property p_dis_neg;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (wr_en && i_sample_ch == 3'(ARB_CH_IBAT) && !i_sample_charging && i_discharge_sense_enable)
      |-> wr_val + i_sample_data == 16'h0000;
  endproperty
  a_dis_neg: assert property (p_dis_neg) else $error("discharge not negative");
  property p_done_hold;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (o_pass_done && i_conv_enable && i_one_shot && !i_reg_rst) |=> o_pass_done;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("one shot end not held");
  property p_seq_rst;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_reg_rst |=> !o_pass_done && !o_conv_active;
  endproperty
  a_seq_rst: assert property (p_seq_rst) else $error("sequencer survives reset");
endmodule : arb_bank
`default_nettype wire

//--- hdl/arb_pkg.sv
// constants for the housekeeping converter result register bank
package arb_pkg;
  localparam logic [7:0] ARB_OFS_DISABLE = 8'h30;
  localparam logic [7:0] ARB_OFS_IBUS = 8'h31;
  localparam logic [7:0] ARB_OFS_IBAT = 8'h33;
  localparam logic [7:0] ARB_OFS_VBUS = 8'h35;
  localparam logic [7:0] ARB_OFS_SRC1 = 8'h37;
  localparam logic [7:0] ARB_OFS_SRC2 = 8'h39;
  localparam logic [7:0] ARB_OFS_VBAT = 8'h3b;
  localparam int ARB_BIT_POS_DL = 7;
  localparam int ARB_BIT_NEG_DL = 6;
  localparam int ARB_BIT_SRC2 = 5;
  localparam int ARB_BIT_SRC1 = 4;
  localparam logic [3:0] ARB_DISABLE_RST = 4'h0;
  localparam logic [15:0] ARB_RESULT_RST = 16'h0000;
  localparam int ARB_NUM_CH = 6;
  localparam int ARB_CH_IBUS = 0;
  localparam int ARB_CH_IBAT = 1;
  localparam int ARB_CH_VBUS = 2;
  localparam int ARB_CH_SRC1 = 3;
  localparam int ARB_CH_SRC2 = 4;
  localparam int ARB_CH_VBAT = 5;
  typedef enum logic [1:0] {ARB_IDLE, ARB_RUN, ARB_DONE} arb_state_t;
endpackage : arb_pkg

//--- hdl/arb_result_mem.sv
// result word store with registered read data
`timescale 1ns/10ps
`default_nettype none
module arb_result_mem #(
  parameter int DEPTH = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_clr,
  input wire logic i_we,
  input wire logic [2:0] i_waddr,
  input wire logic [15:0] i_wdata,
  input wire logic [2:0] i_raddr,
  output logic [15:0] o_rdata
);
  import arb_pkg::*;
  if (DEPTH < 1 || DEPTH > 8)
  begin : g_bad_depth
    $error("depth out of range");
  end
  logic [15:0] mem_reg [DEPTH];
  logic [15:0] rd_reg;
  logic [15:0] rd_next;
  always_comb
  begin
    rd_next = (int'(i_raddr) < DEPTH) ? mem_reg[i_raddr] : 16'h0000;
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rd_reg <= ARB_RESULT_RST;
      for (int k = 0; k < DEPTH; k++) mem_reg[k] <= ARB_RESULT_RST;
    end
    else
    begin
      rd_reg <= rd_next;
      if (i_clr)
        for (int k = 0; k < DEPTH; k++) mem_reg[k] <= ARB_RESULT_RST;
      else if (i_we && int'(i_waddr) < DEPTH)
        mem_reg[i_waddr] <= i_wdata;
    end
  end
  assign o_rdata = rd_reg;
endmodule : arb_result_mem
`default_nettype wire

//--- dv/arb_host.sv
// host model issuing byte accesses to the bank
`timescale 1ns/10ps
`default_nettype none
module arb_host (
  input wire logic i_clk_sys,
  input wire logic i_rvalid,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // one byte access, bus inverted once released
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : acc
  task automatic rd(input logic [7:0] a, output logic v, output logic [7:0] d);
    acc(1'b0, a, 8'h00);
    // answer stands only in the cycle after the strobe
    v = i_rvalid;
    d = i_rdata;
  endtask : rd
  // upper byte first, lower byte next
  task automatic rdw(input logic [7:0] a, output logic v, output logic [15:0] w);
    logic v0;
    logic v1;
    rd(a, v0, w[15:8]);
    rd(a + 8'h01, v1, w[7:0]);
    v = v0 & v1;
  endtask : rdw
endmodule : arb_host
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the converter result bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import arb_pkg::*;
  logic clk, nrst, reg_rst, wr, rd, rvalid, en, one_shot, dse, sv, schg;
  logic p_off, n_off, s2_off, s1_off, active, done;
  logic [7:0] addr, wdata, rdata, dis, b;
  logic [2:0] sch;
  logic [15:0] sdata, w;
  logic [15:0] exp_res [6];
  logic v;
  int err_count, checked, cyc, mx [6], i;
  logic [7:0] ofs [6];
  arb_bank u_arb_bank (.i_clk_sys(clk), .i_nrst(nrst), .i_reg_rst(reg_rst), .i_wr(wr),
    .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_conv_enable(en), .i_one_shot(one_shot), .i_discharge_sense_enable(dse),
    .i_sample_valid(sv), .i_sample_ch(sch), .i_sample_data(sdata),
    .i_sample_charging(schg), .o_pos_dataline_conv_off(p_off),
    .o_neg_dataline_conv_off(n_off), .o_source2_conv_off(s2_off),
    .o_source1_conv_off(s1_off), .o_conv_active(active), .o_pass_done(done));
  arb_host u_arb_host (.i_clk_sys(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_wr(wr),
    .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      conclude();
    end
  end
  // converter sample, model updates only while converting
  task automatic push(input int c, input logic [15:0] d, input logic g, input logic act);
    @(negedge clk);
    sv = 1'b1;
    sch = 3'(c);
    sdata = d;
    schg = g;
    @(negedge clk);
    sv = 1'b0;
    sdata = ~d;
    if (act && !(c == 3 && dis[4]) && !(c == 4 && dis[5]))
      exp_res[c] = (c != 1 || g) ? d : (dse ? ~d + 16'h0001 : 16'h0000);
  endtask : push
  task automatic chkall;
    for (int k = 0; k < 6; k++)
    begin
      u_arb_host.rdw(ofs[k], v, w);
      chk({15'h0, v}, 16'h0001);
      chk(w, exp_res[k]);
    end
  endtask : chkall
  task automatic chkdis;
    u_arb_host.rd(ARB_OFS_DISABLE, v, b);
    chk({8'h00, b}, {8'h00, dis});
    chk({12'h0, p_off, n_off, s2_off, s1_off}, {12'h0, dis[7:4]});
  endtask : chkdis
  task automatic wait_act;
    for (int k = 0; k < 8 && active !== 1'b1; k++)
      @(negedge clk);
    chk({15'h0, active}, 16'h0001);
  endtask : wait_act
  initial
  begin
    {nrst, reg_rst, en, one_shot, dse, sv, schg, sch, sdata} = '0;
    {err_count, checked, cyc} = '0;
    mx = '{5000, 8000, 30000, 30000, 30000, 20000};
    ofs = '{ARB_OFS_IBUS, ARB_OFS_IBAT, ARB_OFS_VBUS, ARB_OFS_SRC1, ARB_OFS_SRC2, ARB_OFS_VBAT};
    exp_res = '{default: ARB_RESULT_RST};
    dis = 8'h00;
    i = $urandom(32'h2d90bd57);
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    chkall();
    chkdis();
    $display("test reset values done");
    dis = 8'($urandom) | 8'h0f;
    u_arb_host.acc(1'b1, ARB_OFS_DISABLE, dis);
    dis = dis & 8'hf0;
    u_arb_host.acc(1'b1, ARB_OFS_IBUS, 8'hff);
    chkdis();
    chkall();
    @(negedge clk);
    reg_rst = 1'b1;
    @(negedge clk);
    reg_rst = 1'b0;
    dis = 8'h00;
    chkdis();
    $display("test disable bits done");
    en = 1'b1;
    wait_act();
    for (i = 0; i < 6; i++)
      push(i, 16'($urandom_range(mx[i])) - (i == 0 ? 16'd2500 : 16'd0), 1'b1, 1'b1);
    push(1, 16'($urandom_range(8000)), 1'b0, 1'b1);
    chkall();
    dse = 1'b1;
    push(1, 16'($urandom_range(8000)), 1'b0, 1'b1);
    chkall();
    $display("test conversions done");
    dis = 8'h30;
    u_arb_host.acc(1'b1, ARB_OFS_DISABLE, dis);
    push(3, 16'h1234, 1'b1, 1'b1);
    push(4, 16'h2345, 1'b1, 1'b1);
    en = 1'b0;
    push(2, 16'h3456, 1'b1, 1'b0);
    chkall();
    $display("test blocking done");
    one_shot = 1'b1;
    en = 1'b1;
    wait_act();
    push(5, 16'h4567, 1'b1, 1'b1);
    @(negedge clk);
    chk({14'h0, done, active}, 16'h0002);
    push(0, 16'h0567, 1'b1, 1'b0);
    chkall();
    $display("test one shot done");
    @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    exp_res = '{default: ARB_RESULT_RST};
    dis = 8'h00;
    chk({15'h0, done}, 16'h0000);
    chkdis();
    chkall();
    $display("test power-on reset done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
